// file: hdl/cst_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01 - Raise completion interrupt when word finishes
// R02 - Mode register write clears completion interrupt
// R03 - Delay mode only in master operation
// R04 - Single receive-only: buffer read starts transfer
// R05 - Single transmit/receive: buffer write starts transfer
// R06 - Slave: software enables channel before master
// R07 - Busy flag set when communication starts
// R08 - Single done: interrupt, clear busy, idle
// R09 - Software leaves control registers alone while busy
// R10 - Continuous receive: dummy read starts, reads reserve
// R11 - Software skips read at second-last interrupt
// R12 - Words via main, extended buffer, shift register
// R13 - First continuous transfer registers two requests
// R14 - Unreserved receive stops, buffer not updated
// R15 - Continuous transmit: first buffer, then buffer write
// R16 - Software writes next word, reads received
// R17 - Unreserved transmit stops, receive buffer unchanged
// R18 - Last transmit/receive word stays in shift
// R19 - First buffer write, shift/extended reads never start
// R20 - Eight-bit length uses only low byte
// R21 - Access meeting request clear is dropped
// R22 - Late write at completion restarts from first buffer
// R23 - Shift exactly data length bits per word
// R24 - Extended buffer and shift keep last words
module cst_ctrl
  import cst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic sdi,
  output logic sdo,
  output logic xfer_done_irq,
  output logic xfer_in_progress
);

  // Control fields of serial_mode_ctrl and serial_clock_sel_reg
  logic channel_op_enable, next_channel_op_enable;
  logic tx_rx_direction_sel, next_tx_rx_direction_sel;
  logic continuous_mode_sel, next_continuous_mode_sel;
  logic data_length_sel, next_data_length_sel;
  logic irq_delay_sel, next_irq_delay_sel;
  logic [2:0] sclk_source_sel, next_sclk_source_sel;
  // Data buffers
  logic [15:0] rx_buffer, next_rx_buffer;
  logic [15:0] rx_buffer_ext, next_rx_buffer_ext;
  logic [15:0] tx_buffer, next_tx_buffer;
  logic [15:0] first_tx_buffer, next_first_tx_buffer;
  logic [15:0] shift_reg, next_shift_reg;
  // Sequencer state
  cst_state_e state, next_state;
  logic [1:0] pending, next_pending;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] div_cnt, next_div_cnt;
  logic sclk_q, next_sclk_q;
  logic sdo_q, next_sdo_q;
  logic irq, next_irq;
  logic s_prev, next_s_prev;
  // Bus data phase
  logic dp_wr, next_dp_wr;
  logic [4:0] dp_addr, next_dp_addr;
  logic [31:0] rdata, next_rdata;

  logic s_sclk, s_sdi;
  logic slave, delay_eff, tick, rise, fall, last_rise, done;
  logic ap, rx_rd, tx_wr, mode_wr, acc, start_fresh;
  logic [4:0] len;
  logic [15:0] mask, wdata, tx_src, fresh_load, next_load, sampled;
  logic [7:0] half;
  logic [31:0] mode_rd;

  // Pin inputs into the system clock domain
  cst_sync #(.WIDTH(2)) cst_sync_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_in({sclk_in, sdi}),
    .q_out({s_sclk, s_sdi})
  );

  // Clock source and serial edge decode
  assign slave = (sclk_source_sel == SEL_SLAVE);
  assign delay_eff = irq_delay_sel & ~slave; // R03
  assign len = data_length_sel ? LEN_16 : LEN_8; // R23
  assign mask = data_length_sel ? MASK_16 : MASK_8; // R20
  assign half = 8'(HALF_BASE << sclk_source_sel);
  assign tick = (div_cnt == 8'h00);
  assign rise = slave ? (s_sclk & ~s_prev) : (tick & ~sclk_q);
  assign fall = slave ? (~s_sclk & s_prev) : (tick & sclk_q);
  assign last_rise = (state == st_shift) & rise & (bit_cnt == 5'(len - 5'h01)); // R23
  assign done = (state == st_fin) & (~delay_eff | tick); // R03
  assign sampled = {shift_reg[14:0], s_sdi} & mask;

  // Bus decode; reads act in the address phase, writes in the data phase
  assign ap = hsel & hready & htrans[1];
  assign rx_rd = ap & ~hwrite & (haddr[ADDR_W-1:0] == ADDR_RXBUF);
  assign tx_wr = dp_wr & (dp_addr == ADDR_TXBUF);
  assign mode_wr = dp_wr & (dp_addr == ADDR_MODE);
  assign wdata = hwdata[15:0] & mask; // R20
  // Only main buffer accesses request a transfer
  assign acc = channel_op_enable & ((rx_rd & ~tx_rx_direction_sel)
             | (tx_wr & tx_rx_direction_sel)); // R04 R05 R19
  assign start_fresh = acc & ((state == st_idle) | (done & (pending == REQ_NONE)));

  // Shift register load values
  assign tx_src = tx_wr ? wdata : tx_buffer;
  assign fresh_load = ~tx_rx_direction_sel ? WORD_RST
                    : (continuous_mode_sel ? first_tx_buffer : tx_src); // R15 R22
  assign next_load = tx_rx_direction_sel ? tx_buffer : WORD_RST;

  // Register read image
  always_comb begin
    mode_rd = RD_ZERO;
    mode_rd[MB_ENABLE] = channel_op_enable;
    mode_rd[MB_DIR] = tx_rx_direction_sel;
    mode_rd[MB_AUTO] = continuous_mode_sel;
    mode_rd[MB_LEN16] = data_length_sel;
    mode_rd[MB_DELAY] = irq_delay_sel;
    mode_rd[MB_BUSY] = xfer_in_progress;
    mode_rd[MB_IRQ] = irq;
  end

  // Bus slave next values
  always_comb begin
    next_dp_wr = ap & hwrite & (hsize == HSIZE_WORD);
    next_dp_addr = haddr[ADDR_W-1:0];
    next_rdata = rdata;
    if (ap & ~hwrite) begin
      case (haddr[ADDR_W-1:0])
        ADDR_MODE: next_rdata = mode_rd;
        ADDR_CLKSEL: next_rdata = {29'h0, sclk_source_sel};
        ADDR_RXBUF: next_rdata = {16'h0, rx_buffer & mask};
        ADDR_RXEXT: next_rdata = {16'h0, rx_buffer_ext & mask};
        ADDR_TXBUF: next_rdata = {16'h0, tx_buffer & mask};
        ADDR_FTXBUF: next_rdata = {16'h0, first_tx_buffer & mask};
        ADDR_SHIFT: next_rdata = {16'h0, shift_reg & mask}; // R18 R24
        default: next_rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dp_wr <= 1'b0;
      dp_addr <= ADDR_MODE;
      rdata <= RD_ZERO;
    end else begin
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      rdata <= next_rdata;
    end
  end

  // Control registers, buffers and transfer sequencer next values
  always_comb begin
    next_channel_op_enable = channel_op_enable;
    next_tx_rx_direction_sel = tx_rx_direction_sel;
    next_continuous_mode_sel = continuous_mode_sel;
    next_data_length_sel = data_length_sel;
    next_irq_delay_sel = irq_delay_sel;
    next_sclk_source_sel = sclk_source_sel;
    next_rx_buffer = rx_buffer;
    next_rx_buffer_ext = rx_buffer_ext;
    next_tx_buffer = tx_buffer;
    next_first_tx_buffer = first_tx_buffer;
    next_shift_reg = shift_reg;
    next_state = state;
    next_pending = pending;
    next_bit_cnt = bit_cnt;
    next_sdo_q = sdo_q;
    next_irq = irq;
    next_s_prev = s_sclk;
    next_sclk_q = sclk_q;
    next_div_cnt = 8'(half - DIV_ONE);

    // Register writes
    if (mode_wr) begin
      next_channel_op_enable = hwdata[MB_ENABLE];
      next_tx_rx_direction_sel = hwdata[MB_DIR];
      next_continuous_mode_sel = hwdata[MB_AUTO];
      next_data_length_sel = hwdata[MB_LEN16];
      next_irq_delay_sel = hwdata[MB_DELAY] & ~slave; // R03
      next_irq = 1'b0; // R02
    end
    if (dp_wr & (dp_addr == ADDR_CLKSEL)) begin
      next_sclk_source_sel = hwdata[2:0];
    end
    if (tx_wr) begin
      next_tx_buffer = wdata;
    end
    if (dp_wr & (dp_addr == ADDR_FTXBUF)) begin
      next_first_tx_buffer = wdata; // R19
    end

    // Master clock divider runs while a word is active
    if ((state != st_idle) & ~slave) begin
      next_div_cnt = tick ? 8'(half - DIV_ONE) : 8'(div_cnt - DIV_ONE);
    end

    case (state)
      st_idle: begin
        next_sclk_q = 1'b1;
        if (start_fresh) begin
          next_state = st_shift; // R04 R05 R07
          next_shift_reg = fresh_load;
          next_bit_cnt = 5'h00;
          next_pending = continuous_mode_sel ? REQ_CONT : REQ_SINGLE; // R10 R13 R15
        end
      end
      st_shift: begin
        if (~slave & tick) begin
          next_sclk_q = ~sclk_q;
        end
        if (fall) begin
          next_sdo_q = tx_rx_direction_sel & (data_length_sel ? shift_reg[15] : shift_reg[7]); // R23
        end
        if (rise) begin
          next_shift_reg = sampled; // R23
          next_bit_cnt = 5'(bit_cnt + 5'h01);
        end
        if (last_rise) begin
          next_state = st_fin;
          next_pending = 2'(pending - REQ_SINGLE); // R21
        end else if (acc & continuous_mode_sel & (pending != REQ_CONT)) begin
          next_pending = 2'(pending + REQ_SINGLE); // R10 R16
        end
      end
      st_fin: begin
        if (done) begin
          next_irq = 1'b1; // R01 R08
          // Buffers take the word in single mode, or when the continuous run goes on
          if (~continuous_mode_sel | (pending != REQ_NONE)) begin
            next_rx_buffer = shift_reg; // R12 R14 R17
            if (~tx_rx_direction_sel) begin
              next_rx_buffer_ext = shift_reg; // R12
            end
          end
          if (pending != REQ_NONE) begin
            next_state = st_shift;
            next_shift_reg = next_load;
            next_bit_cnt = 5'h00;
          end else if (start_fresh) begin
            next_state = st_shift; // R22
            next_shift_reg = fresh_load;
            next_bit_cnt = 5'h00;
            next_pending = continuous_mode_sel ? REQ_CONT : REQ_SINGLE; // R13
          end else begin
            next_state = st_idle; // R08 R14 R17 R18 R24
          end
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase

    // Disabled channel halts and clears the shift register
    if (~channel_op_enable) begin
      next_state = st_idle;
      next_pending = REQ_NONE;
      next_shift_reg = WORD_RST;
      next_sclk_q = 1'b1;
      next_sdo_q = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      channel_op_enable <= 1'b0;
      tx_rx_direction_sel <= 1'b0;
      continuous_mode_sel <= 1'b0;
      data_length_sel <= 1'b0;
      irq_delay_sel <= 1'b0;
      sclk_source_sel <= SEL_RST;
      rx_buffer <= WORD_RST;
      rx_buffer_ext <= WORD_RST;
      tx_buffer <= WORD_RST;
      first_tx_buffer <= WORD_RST;
      shift_reg <= WORD_RST;
      state <= st_idle;
      pending <= REQ_NONE;
      bit_cnt <= 5'h00;
      div_cnt <= 8'h00;
      sclk_q <= 1'b1;
      sdo_q <= 1'b0;
      irq <= 1'b0;
      s_prev <= 1'b1;
    end else begin
      channel_op_enable <= next_channel_op_enable;
      tx_rx_direction_sel <= next_tx_rx_direction_sel;
      continuous_mode_sel <= next_continuous_mode_sel;
      data_length_sel <= next_data_length_sel;
      irq_delay_sel <= next_irq_delay_sel;
      sclk_source_sel <= next_sclk_source_sel;
      rx_buffer <= next_rx_buffer;
      rx_buffer_ext <= next_rx_buffer_ext;
      tx_buffer <= next_tx_buffer;
      first_tx_buffer <= next_first_tx_buffer;
      shift_reg <= next_shift_reg;
      state <= next_state;
      pending <= next_pending;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      sclk_q <= next_sclk_q;
      sdo_q <= next_sdo_q;
      irq <= next_irq;
      s_prev <= next_s_prev;
    end
  end

  // Outputs
  assign hrdata = rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sclk_out = sclk_q;
  assign sclk_oe = ~slave;
  assign sdo = sdo_q;
  assign xfer_done_irq = irq;
  assign xfer_in_progress = (state != st_idle); // R07 R08

endmodule : cst_ctrl
`default_nettype wire

// file: hdl/cst_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser, one chain per bit
module cst_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          meta[i] <= 1'b1;
          q_out[i] <= 1'b1;
        end else begin
          meta[i] <= d_in[i];
          q_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : cst_sync
`default_nettype wire

// file: include/cst_pkg.sv
// Shared constants of the clocked serial transfer channel
`default_nettype none
package cst_pkg;

  // Register byte offsets, one aligned word each
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_CLKSEL = 5'h04;
  localparam logic [4:0] ADDR_RXBUF = 5'h08;
  localparam logic [4:0] ADDR_RXEXT = 5'h0c;
  localparam logic [4:0] ADDR_TXBUF = 5'h10;
  localparam logic [4:0] ADDR_FTXBUF = 5'h14;
  localparam logic [4:0] ADDR_SHIFT = 5'h18;

  // Bit positions inside serial_mode_ctrl
  localparam int MB_ENABLE = 0;
  localparam int MB_DIR = 1;
  localparam int MB_AUTO = 2;
  localparam int MB_LEN16 = 3;
  localparam int MB_DELAY = 4;
  localparam int MB_BUSY = 5;
  localparam int MB_IRQ = 6;

  // Clock source code that selects slave operation
  localparam logic [2:0] SEL_SLAVE = 3'h7;
  localparam logic [2:0] SEL_RST = 3'h0;

  // Data length in bits and matching masks
  localparam int WORD_W = 16;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [15:0] MASK_8 = 16'h00ff;
  localparam logic [15:0] MASK_16 = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Pending request counts
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_SINGLE = 2'h1;
  localparam logic [1:0] REQ_CONT = 2'h2;

  // Master serial clock half period is HALF_BASE << sclk_source_sel cycles
  localparam logic [7:0] HALF_BASE = 8'h02;
  localparam logic [7:0] DIV_ONE = 8'h01;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {st_idle, st_shift, st_fin} cst_state_e;

endpackage : cst_pkg
`default_nettype wire

// file: verif/cst_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the serial transfer channel
module cst_ctrl_props
  import cst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic xfer_done_irq,
  input wire logic xfer_in_progress
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic take, rd_rx, wr_tx, wr_mode, sclk_q, busy_q;
  logic [5:0] falls, next_falls;
  logic [8:0] idle, next_idle;
  // Decode of accepted bus transfers
  assign take = hsel && hready && htrans[1];
  assign rd_rx = take && !hwrite && haddr[4:0] == ADDR_RXBUF;
  assign wr_tx = take && hwrite && hsize == HSIZE_WORD && haddr[4:0] == ADDR_TXBUF;
  assign wr_mode = take && hwrite && hsize == HSIZE_WORD && haddr[4:0] == ADDR_MODE;
  // Serial clock falls in this run, cycles spent idle
  always_comb begin
    next_falls = falls + 6'(sclk_q && !sclk_out);
    if (xfer_in_progress && !busy_q) begin
      next_falls = 6'h0;
    end
    next_idle = idle + 9'(idle != 9'h1ff);
    if (xfer_in_progress) begin
      next_idle = 9'h0;
    end
  end
  // Helper registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      falls <= 6'h0;
      idle <= 9'h0;
      sclk_q <= 1'h1;
      busy_q <= 1'h0;
    end else begin
      falls <= next_falls;
      idle <= next_idle;
      sclk_q <= sclk_out;
      busy_q <= xfer_in_progress;
    end
  end
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not OKAY");
  property p_irq_clear; wr_mode ##1 !xfer_in_progress |-> ##1 !xfer_done_irq; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("mode write left irq set");
  property p_start; $rose(xfer_in_progress) |-> $past(rd_rx) || $past(wr_tx, 2); endproperty
  a_start: assert property (p_start) else $error("busy rose without a start access");
  property p_busy_min; $rose(xfer_in_progress) |-> xfer_in_progress[*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy dropped too soon");
  property p_done; $fell(xfer_in_progress) |-> ##[0:300] xfer_done_irq; endproperty
  a_done: assert property (p_done) else $error("no irq after transfer end");
  property p_irq_cause; $rose(xfer_done_irq) |-> idle < 9'h12c; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without recent transfer");
  property p_bits; $rose(xfer_done_irq) && sclk_oe |-> falls != 6'h0 && falls[2:0] == 3'h0; endproperty
  a_bits: assert property (p_bits) else $error("clock count not whole words");
  property p_idle_high; !xfer_in_progress && sclk_oe |-> sclk_out; endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial clock low while idle");
  c_irq: cover property ($rose(xfer_done_irq));
  c_mode: cover property (wr_mode);
  c_slave_end: cover property ($fell(xfer_in_progress) && !sclk_oe);
endmodule : cst_ctrl_props
`default_nettype wire

// file: verif/cst_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the serial transfer channel
module cst_ctrl_tb
  import cst_pkg::*;
;
  localparam logic [31:0] EN = 32'h1 << MB_ENABLE;
  localparam logic [31:0] DIR = 32'h1 << MB_DIR;
  localparam logic [31:0] AUTO = 32'h1 << MB_AUTO;
  localparam logic [31:0] L16 = 32'h1 << MB_LEN16;
  logic clk_sys, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdp = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pat, d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic hreadyout, hresp, sclk_in, sclk_out, sclk_oe, sdi, sdo, xfer_done_irq, xfer_in_progress;
  logic [31:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  cst_ctrl cst_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sdi(sdi), .sdo(sdo), .xfer_done_irq(xfer_done_irq), .xfer_in_progress(xfer_in_progress));
  cst_peer cst_peer_inst (.sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo(sdo), .sclk_in(sclk_in), .sdi(sdi));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // Bounded wait for ready at a rising edge
  task wready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin
      failures++;
      finish_test;
    end
  endtask : wready
  // Bounded wait for irq or busy to reach a level
  task wait_sig(input logic irq, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((irq ? xfer_done_irq : xfer_in_progress) !== v && n < 3000);
    if (n >= 3000) begin
      failures++;
      finish_test;
    end
  endtask : wait_sig
  // One single AHB-Lite word transfer
  task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    wready;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdp <= !w;
    wready;
    rdp <= 1'h0;
  endtask : bus
  task rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask : rd
  // Read data checked against the oldest note
  always @(posedge clk_sys) if (rdp && hreadyout) begin
    chk(hrdata, exp_q.pop_front());
  end
  // Reset, map checks, then the transfer modes
  initial begin
    void'($urandom(32'h7b6f));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    rd(ADDR_MODE, 32'h0);
    bus(1'h1, 5'h1c, 32'hffff);
    rd(5'h1c, 32'h0);
    bus(1'h1, ADDR_CLKSEL, 32'h1);
    pat = $urandom;
    cst_peer_inst.pat = pat;
    bus(1'h1, ADDR_MODE, EN | L16);
    rd(ADDR_RXBUF, 32'h0);
    wait_sig(1'h0, 1'h0);
    chk({31'h0, xfer_done_irq}, 32'h1);
    rd(ADDR_SHIFT, {16'h0, pat[31:16]});
    #1 chk({31'h0, xfer_in_progress}, 32'h0);
    rd(ADDR_RXBUF, {16'h0, pat[31:16]});
    wait_sig(1'h0, 1'h0);
    // Single transmit/receive, 8-bit
    pat = $urandom;
    d = $urandom;
    cst_peer_inst.pat = pat;
    bus(1'h1, ADDR_MODE, EN | DIR);
    #1 chk({31'h0, xfer_done_irq}, 32'h0);
    bus(1'h1, ADDR_FTXBUF, 32'h5a);
    #1 chk({31'h0, xfer_in_progress}, 32'h0);
    bus(1'h1, ADDR_TXBUF, d);
    #1 chk({31'h0, xfer_in_progress}, 32'h1);
    wait_sig(1'h0, 1'h0);
    chk({24'h0, cst_peer_inst.rx[7:0]}, {24'h0, d[7:0]});
    rd(ADDR_RXBUF, {24'h0, pat[31:24]});
    // Continuous transmit/receive, three words
    pat = $urandom;
    d = $urandom;
    cst_peer_inst.pat = pat;
    bus(1'h1, ADDR_MODE, EN | DIR | AUTO);
    bus(1'h1, ADDR_FTXBUF, d);
    bus(1'h1, ADDR_TXBUF, d >> 8);
    wait_sig(1'h1, 1'h1);
    bus(1'h1, ADDR_TXBUF, d >> 16);
    wait_sig(1'h0, 1'h0);
    chk({8'h0, cst_peer_inst.rx[23:0]}, {8'h0, d[7:0], d[15:8], d[23:16]});
    rd(ADDR_RXBUF, {24'h0, pat[23:16]});
    rd(ADDR_SHIFT, {24'h0, pat[15:8]});
    // Continuous receive-only, three words
    d = pat;
    pat = $urandom;
    cst_peer_inst.pat = pat;
    bus(1'h1, ADDR_MODE, EN | AUTO);
    rd(ADDR_RXBUF, {24'h0, d[23:16]});
    wait_sig(1'h1, 1'h1);
    rd(ADDR_RXBUF, {24'h0, pat[31:24]});
    wait_sig(1'h0, 1'h0);
    rd(ADDR_RXEXT, {24'h0, pat[23:16]});
    rd(ADDR_SHIFT, {24'h0, pat[15:8]});
    rd(ADDR_RXBUF, {24'h0, pat[23:16]});
    wait_sig(1'h0, 1'h0);
    // Slave operation under the peer's clock
    pat = $urandom;
    d = $urandom;
    cst_peer_inst.pat = pat;
    bus(1'h1, ADDR_CLKSEL, {29'h0, SEL_SLAVE});
    bus(1'h1, ADDR_MODE, EN | DIR | L16);
    bus(1'h1, ADDR_TXBUF, d);
    #3 chk({31'h0, sclk_oe}, 32'h0);
    cst_peer_inst.frame(16);
    wait_sig(1'h0, 1'h0);
    chk({16'h0, cst_peer_inst.rx[15:0]}, {16'h0, d[15:0]});
    rd(ADDR_RXBUF, {16'h0, pat[31:16]});
    bus(1'h1, ADDR_MODE, EN | DIR | L16 | (32'h1 << MB_DELAY));
    rd(ADDR_MODE, EN | DIR | L16);
    // Delay mode taken in master operation, then a transfer with it ends with irq set
    d = $urandom;
    bus(1'h1, ADDR_CLKSEL, 32'h1);
    bus(1'h1, ADDR_MODE, EN | DIR | (32'h1 << MB_DELAY));
    rd(ADDR_MODE, EN | DIR | (32'h1 << MB_DELAY));
    bus(1'h1, ADDR_TXBUF, d);
    wait_sig(1'h0, 1'h0);
    chk({31'h0, xfer_done_irq}, 32'h1);
    chk({24'h0, cst_peer_inst.rx[7:0]}, {24'h0, d[7:0]});
    finish_test;
  end
endmodule : cst_ctrl_tb
bind cst_ctrl cst_ctrl_props cst_ctrl_props_inst (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .xfer_done_irq(xfer_done_irq),
  .xfer_in_progress(xfer_in_progress));
`default_nettype wire

// file: verif/cst_peer.sv
`timescale 1ns/1ps
`default_nettype none
// External serial device: slave to our clock, master with its own
module cst_peer
(
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic sdo,
  output logic sclk_in,
  output logic sdi
);
  logic [31:0] pat = 32'h0;
  logic [31:0] rx = 32'h0;
  initial begin
    sclk_in = 1'h1;
    sdi = 1'h0;
  end
  // Slave role: drive on fall, sample on rise, then spoil the line
  always @(negedge sclk_out) if (sclk_oe) begin
    sdi = pat[31];
    pat = {pat[30:0], 1'h0};
  end
  always @(posedge sclk_out) if (sclk_oe) begin
    rx = {rx[30:0], sdo};
    sdi = ~sdi;
  end
  // Master role: 64 ns clock, only inside the frame
  task automatic frame(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_in = 1'h0;
      sdi = pat[31];
      pat = {pat[30:0], 1'h0};
      #32 sclk_in = 1'h1;
      #32 rx = {rx[30:0], sdo};
    end
    sdi = ~sdi;
  endtask : frame
endmodule : cst_peer
`default_nettype wire
